/* File: rtl/eirq_pkg.sv */
package eirq_pkg;

    // control register location and field positions
    localparam logic [5:0] EIRQ_CTRL_ADDR    = 6'h37;
    localparam int         FLT_LEN_BIT       = 7;
    localparam int         PIN_FUNC_BIT      = 6;
    localparam int         EDGE_SEL_BIT      = 1;
    localparam logic [7:0] EIRQ_CTRL_RESET   = 8'h00;
    localparam logic [7:0] EIRQ_CTRL_MASK    = 8'hC2;

    // noise reject figures in high-frequency clock periods (clk_sys_in is that clock)
    localparam int REJ_AC_FC      = 2;
    localparam int ACC_AC_FC      = 7;
    localparam int REJ_B_SHORT_FC = 15;
    localparam int ACC_B_SHORT_FC = 49;
    localparam int REJ_B_LONG_FC  = 63;
    localparam int ACC_B_LONG_FC  = 193;
    localparam int LEN_SWITCH_FC  = 64;

    // filter counter width and thresholds taken midway between reject and accept
    localparam int         FLT_CNT_W     = 8;
    localparam logic [7:0] THRESH_AC     = 8'((REJ_AC_FC + ACC_AC_FC) / 2);
    localparam logic [7:0] THRESH_B_SHRT = 8'((REJ_B_SHORT_FC + ACC_B_SHORT_FC) / 2);
    localparam logic [7:0] THRESH_B_LONG = 8'((REJ_B_LONG_FC + ACC_B_LONG_FC) / 2);

    // pin idle level after reset (external interrupt pins idle high)
    localparam logic PIN_IDLE = 1'b1;

    // instruction fetch region forbidden for code (data memory and registers)
    localparam logic [15:0] TRAP_LO = 16'h0000;
    localparam logic [15:0] TRAP_HI = 16'h00FF;

endpackage

/* File: rtl/eirq_filter.sv */
`timescale 1ns/10ps
module eirq_filter
    import eirq_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_sys_in,
    input  wire logic                 rst_in,
    // raw pin and threshold
    input  wire logic                 pin_in,
    input  wire logic [FLT_CNT_W-1:0] thresh_in,
    // filtered level and edges
    output logic                      level_out,
    output logic                      rise_out,
    output logic                      fall_out
);

    logic                 sync1_q;
    logic                 sync2_q;
    logic [FLT_CNT_W-1:0] cnt_q;
    logic [FLT_CNT_W-1:0] cnt_inc;

    assign cnt_inc = cnt_q + 8'h01;

    // two-stage synchroniser; only sync2_q is looked at
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_q <= PIN_IDLE;
            sync2_q <= PIN_IDLE;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // count consecutive samples that differ from the accepted level; any
    // return to the old level restarts the count, so short glitches vanish
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q     <= '0;
            level_out <= PIN_IDLE;
            rise_out  <= 1'b0;
            fall_out  <= 1'b0;
        end else begin
            rise_out <= 1'b0;
            fall_out <= 1'b0;
            if (sync2_q == level_out) begin
                cnt_q <= '0;
            end else if (cnt_inc >= thresh_in) begin
                cnt_q     <= '0;
                level_out <= sync2_q;
                rise_out  <= sync2_q;
                fall_out  <= !sync2_q;
            end else begin
                cnt_q <= cnt_inc;
            end
        end
    end

    chk_flt_stable_count: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $changed(level_out) |-> ($past(cnt_q) + 8'h01 >= $past(thresh_in)))
        else $error("filter level changed before the stable count was reached");

endmodule

/* File: rtl/eirq_addr_trap.sv */
`timescale 1ns/10ps
module eirq_addr_trap
    import eirq_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // fetch monitor
    input  wire logic        fetch_valid_in,
    input  wire logic [15:0] fetch_addr_in,
    input  wire logic        trap_reset_sel_in,
    input  wire logic        trap_ack_in,
    // results
    output logic             trap_reset_out,
    output logic             trap_irq_out,
    output logic             trap_abort_out
);

    logic hit;

    // a fetch inside the forbidden region is a trap
    assign hit = fetch_valid_in && (fetch_addr_in >= TRAP_LO) && (fetch_addr_in <= TRAP_HI);

    // reset request and abort are single pulses; the interrupt is sticky and
    // does not look at any NMI state, so it preempts an NMI service
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            trap_reset_out <= 1'b0;
            trap_irq_out   <= 1'b0;
            trap_abort_out <= 1'b0;
        end else begin
            trap_reset_out <= hit && trap_reset_sel_in;
            trap_abort_out <= hit && !trap_reset_sel_in;
            if (hit && !trap_reset_sel_in) begin
                trap_irq_out <= 1'b1;
            end else if (trap_ack_in) begin
                trap_irq_out <= 1'b0;
            end
        end
    end

    chk_trap_reset_sel: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        hit && trap_reset_sel_in |=> trap_reset_out && !trap_abort_out)
        else $error("trap with reset selected did not raise reset");

    chk_trap_irq_sel: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        hit && !trap_reset_sel_in |=> trap_irq_out && trap_abort_out && !trap_reset_out)
        else $error("trap with interrupt selected did not raise interrupt");

endmodule

/* File: rtl/eirq_ext_irq_ctrl.sv */
`timescale 1ns/10ps
module eirq_ext_irq_ctrl
    import eirq_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // special function register access
    input  wire logic [5:0]  sfr_addr_in,
    input  wire logic        sfr_wr_in,
    input  wire logic        sfr_rd_in,
    input  wire logic [7:0]  sfr_wdata_in,
    output logic      [7:0]  sfr_rdata_out,
    // external interrupt pins
    input  wire logic        shared_port_bit_in,
    input  wire logic        ext_irq_b_in,
    input  wire logic        ext_irq_c_in,
    // shared pin port function
    input  wire logic        port_latch_in,
    input  wire logic        port_dir_out_in,
    output logic             shared_port_bit_out,
    output logic             shared_port_bit_oe_out,
    output logic             shared_port_bit_rd_out,
    // cpu interrupt interface
    input  wire logic        master_irq_enable_in,
    input  wire logic        irq_a_enable_flag_in,
    input  wire logic        irq_b_enable_flag_in,
    input  wire logic        irq_c_enable_flag_in,
    input  wire logic        irq_a_clear_in,
    input  wire logic        irq_b_clear_in,
    input  wire logic        irq_c_clear_in,
    input  wire logic        nmi_active_in,
    output logic             irq_a_latch_out,
    output logic             irq_b_latch_out,
    output logic             irq_c_latch_out,
    output logic             irq_a_req_out,
    output logic             irq_b_req_out,
    output logic             irq_c_req_out,
    // address trap
    input  wire logic        fetch_valid_in,
    input  wire logic [15:0] fetch_addr_in,
    input  wire logic        wdt_trap_reset_sel_in,
    input  wire logic        trap_ack_in,
    output logic             trap_reset_out,
    output logic             address_trap_irq_out,
    output logic             trap_abort_out
);

    logic [7:0]           ext_irq_ctrl_q;
    logic                 filter_len_sel;
    logic                 pin_func_sel;
    logic                 edge_polarity_sel;
    logic [FLT_CNT_W-1:0] thresh_b;
    logic                 a_fall;
    logic                 b_rise;
    logic                 b_fall;
    logic                 c_fall;
    logic                 b_edge;
    logic                 ctrl_hit;

    assign filter_len_sel    = ext_irq_ctrl_q[FLT_LEN_BIT];
    assign pin_func_sel      = ext_irq_ctrl_q[PIN_FUNC_BIT];
    assign edge_polarity_sel = ext_irq_ctrl_q[EDGE_SEL_BIT];
    assign ctrl_hit          = (sfr_addr_in == EIRQ_CTRL_ADDR);

    // control register; unimplemented bits are never stored so they read zero
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ext_irq_ctrl_q <= EIRQ_CTRL_RESET;
        end else if (sfr_wr_in && ctrl_hit) begin
            ext_irq_ctrl_q <= sfr_wdata_in & EIRQ_CTRL_MASK;
        end
    end

    // read data registered one cycle after the strobe; other addresses give zero
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_rd_in && ctrl_hit) begin
            sfr_rdata_out <= ext_irq_ctrl_q;
        end else begin
            sfr_rdata_out <= 8'h00;
        end
    end

    // threshold follows the length bit at once, well inside the 64-period limit;
    // a count in flight is judged against the new threshold, which is why
    // software keeps the input disabled while rewriting
    assign thresh_b = filter_len_sel ? THRESH_B_SHRT : THRESH_B_LONG;

    // shared pin: the port drives only when the interrupt function is off
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            shared_port_bit_out    <= 1'b0;
            shared_port_bit_oe_out <= 1'b0;
            shared_port_bit_rd_out <= 1'b0;
        end else begin
            shared_port_bit_out    <= port_latch_in;
            shared_port_bit_oe_out <= port_dir_out_in && !pin_func_sel;
            shared_port_bit_rd_out <= shared_port_bit_in;
        end
    end

    // three noise filters; a and c share the fixed threshold
    eirq_filter u_filt_a (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .pin_in     (shared_port_bit_in),
        .thresh_in  (THRESH_AC),
        .level_out  (),
        .rise_out   (),
        .fall_out   (a_fall)
    );

    eirq_filter u_filt_b (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .pin_in     (ext_irq_b_in),
        .thresh_in  (thresh_b),
        .level_out  (),
        .rise_out   (b_rise),
        .fall_out   (b_fall)
    );

    eirq_filter u_filt_c (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .pin_in     (ext_irq_c_in),
        .thresh_in  (THRESH_AC),
        .level_out  (),
        .rise_out   (),
        .fall_out   (c_fall)
    );

    // edge choice for input b
    assign b_edge = edge_polarity_sel ? b_fall : b_rise;

    // latches; a set in the same cycle as a clear wins. a port-mode pin that
    // toggles its own output cannot set a falsely, as latch a sets only while the function bit is on
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            irq_a_latch_out <= 1'b0;
        end else if (a_fall && pin_func_sel) begin
            irq_a_latch_out <= 1'b1;
        end else if (irq_a_clear_in) begin
            irq_a_latch_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            irq_b_latch_out <= 1'b0;
        end else if (b_edge) begin
            irq_b_latch_out <= 1'b1;
        end else if (irq_b_clear_in) begin
            irq_b_latch_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            irq_c_latch_out <= 1'b0;
        end else if (c_fall) begin
            irq_c_latch_out <= 1'b1;
        end else if (irq_c_clear_in) begin
            irq_c_latch_out <= 1'b0;
        end
    end

    // requests to the cpu: latch gated by master and individual enables
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            irq_a_req_out <= 1'b0;
            irq_b_req_out <= 1'b0;
            irq_c_req_out <= 1'b0;
        end else begin
            irq_a_req_out <= irq_a_latch_out && master_irq_enable_in
                             && irq_a_enable_flag_in && pin_func_sel;
            irq_b_req_out <= irq_b_latch_out && master_irq_enable_in && irq_b_enable_flag_in;
            irq_c_req_out <= irq_c_latch_out && master_irq_enable_in && irq_c_enable_flag_in;
        end
    end

    // address trap detection, selected by the watchdog control bit
    eirq_addr_trap u_trap (
        .clk_sys_in        (clk_sys_in),
        .rst_in            (rst_in),
        .fetch_valid_in    (fetch_valid_in),
        .fetch_addr_in     (fetch_addr_in),
        .trap_reset_sel_in (wdt_trap_reset_sel_in),
        .trap_ack_in       (trap_ack_in),
        .trap_reset_out    (trap_reset_out),
        .trap_irq_out      (address_trap_irq_out),
        .trap_abort_out    (trap_abort_out)
    );

    // checks on the control register and latches
    chk_ctrl_reserved_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        sfr_rd_in && !ctrl_hit |=> sfr_rdata_out == 8'h00 && (ext_irq_ctrl_q & 8'h3D) == 8'h00)
        else $error("reserved control bits or unmapped read not zero");

    chk_ctrl_write_read: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        sfr_wr_in && ctrl_hit ##1 sfr_rd_in && ctrl_hit && !sfr_wr_in
        |=> sfr_rdata_out == ($past(sfr_wdata_in, 2) & 8'hC2))
        else $error("control register did not read back the written fields");

    chk_pin_func_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !pin_func_sel && !irq_a_latch_out |=> !irq_a_latch_out)
        else $error("latch a set while shared pin is a port");

    chk_pad_input_mode: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        pin_func_sel |=> !shared_port_bit_oe_out)
        else $error("shared pin driven while routed to interrupt a");

    chk_a_fall_sets: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        a_fall && pin_func_sel |=> irq_a_latch_out ##1 irq_a_latch_out || $past(irq_a_clear_in))
        else $error("falling edge on input a not latched");

    chk_b_edge_select: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (b_rise && !edge_polarity_sel) || (b_fall && edge_polarity_sel) |=> irq_b_latch_out)
        else $error("selected edge on input b not latched");

    chk_b_wrong_edge: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !irq_b_latch_out && b_rise && edge_polarity_sel |=> !irq_b_latch_out)
        else $error("unselected edge on input b latched");

    chk_b_threshold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(filter_len_sel) |-> thresh_b == 8'h20 ##1 thresh_b == 8'h20 || !filter_len_sel)
        else $error("short filter threshold not applied");

    chk_c_fall_sets: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        c_fall |=> irq_c_latch_out)
        else $error("falling edge on input c not latched");

    chk_a_req_cause: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(irq_a_req_out) |-> $past(master_irq_enable_in) && $past(irq_a_enable_flag_in)
                                 && $past(pin_func_sel) && $past(irq_a_latch_out))
        else $error("request a raised without all enables");

    // the trap must not wait for an nmi service to finish
    chk_trap_in_nmi: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        nmi_active_in && fetch_valid_in && fetch_addr_in <= TRAP_HI && !wdt_trap_reset_sel_in
        |=> trap_abort_out && address_trap_irq_out)
        else $error("trap during nmi not taken at once");

    chk_trap_no_fetch: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !fetch_valid_in |=> !trap_reset_out && !trap_abort_out)
        else $error("trap raised without a fetch");

    chk_trap_outside: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fetch_valid_in && fetch_addr_in > TRAP_HI |=> !trap_reset_out && !trap_abort_out)
        else $error("trap raised for a permitted fetch");

    // register side: masked store, no stray updates, idle read data
    chk_ctrl_write_mask: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        sfr_wr_in && ctrl_hit |=> ext_irq_ctrl_q == ($past(sfr_wdata_in) & 8'hC2))
        else $error("control write not stored with reserved bits dropped");

    chk_ctrl_no_stray_wr: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !(sfr_wr_in && ctrl_hit) |=> $stable(ext_irq_ctrl_q))
        else $error("control register changed without a write to it");

    chk_rdata_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !sfr_rd_in |=> sfr_rdata_out == 8'h00)
        else $error("read data not zero without a read");

    // thresholds must sit between the reject and accept widths
    chk_b_long_range: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !filter_len_sel |-> thresh_b >= 8'h3F && thresh_b <= 8'hC1)
        else $error("long filter threshold outside reject and accept widths");

    chk_b_short_range: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        filter_len_sel |-> thresh_b >= 8'h0F && thresh_b <= 8'h31)
        else $error("short filter threshold outside reject and accept widths");

    // latches set only on their own filtered edge
    chk_a_fall_only: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !irq_a_latch_out && !a_fall |=> !irq_a_latch_out)
        else $error("latch a set without a filtered falling edge");

    chk_b_edge_only: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !irq_b_latch_out && !b_edge |=> !irq_b_latch_out)
        else $error("latch b set without its selected edge");

    chk_c_fall_only: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !irq_c_latch_out && !c_fall |=> !irq_c_latch_out)
        else $error("latch c set without a filtered falling edge");

    chk_b_set_wins: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        b_edge && irq_b_clear_in |=> irq_b_latch_out)
        else $error("clear beat a new edge on latch b");

    // requests stay low while any enable is missing
    chk_a_req_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !pin_func_sel |=> !irq_a_req_out)
        else $error("request a raised while shared pin is a port");

    chk_a_req_enables: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !master_irq_enable_in || !irq_a_enable_flag_in |=> !irq_a_req_out)
        else $error("request a raised with an enable missing");

    chk_b_req_enables: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !master_irq_enable_in || !irq_b_enable_flag_in |=> !irq_b_req_out)
        else $error("request b raised with an enable missing");

    chk_c_req_enables: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !master_irq_enable_in || !irq_c_enable_flag_in |=> !irq_c_req_out)
        else $error("request c raised with an enable missing");

    // shared pin behaves as a plain port bit while the function bit is clear
    chk_port_out_follow: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        port_dir_out_in && !pin_func_sel |=> shared_port_bit_oe_out)
        else $error("port output mode not driven onto the shared pin");

    chk_port_data_follow: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        1'b1 |=> shared_port_bit_out == $past(port_latch_in))
        else $error("shared pin output does not follow the port latch");

    chk_shared_pin_rd: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        1'b1 |=> shared_port_bit_rd_out == $past(shared_port_bit_in))
        else $error("shared pin read does not follow the pad");

    // main scenarios
    cov_a_latched: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        pin_func_sel && a_fall ##2 irq_a_req_out);

    cov_b_long_filter: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        !filter_len_sel && b_edge);

    cov_trap_during_nmi: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        nmi_active_in && trap_abort_out);

    cov_trap_reset: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        trap_reset_out);

    cov_b_wrong_edge: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        edge_polarity_sel && b_rise && !irq_b_latch_out);

endmodule

/* File: test/eirq_pin_src.sv */
`timescale 1ns/10ps
// far side model: three interrupt sources, each pin pulled up when released
module eirq_pin_src (
    // clock that paces pin changes
    input  wire logic       clk_sys_in,
    // pin levels, index 0 = a, 1 = b, 2 = c
    output logic      [2:0] pins_out
);
    logic [2:0] low_q;  // pins actively pulled low

    // a released pin reads high through its pull-up, not its last driven value
    assign pins_out = ~low_q;

    initial begin
        low_q = 3'h0;
    end

    // one low pulse of a set width; pins only move on falling edges
    task automatic low_pulse(input int which, input int width);
        @(negedge clk_sys_in);
        low_q[which] = 1'b1;
        repeat (width) @(negedge clk_sys_in);
        low_q[which] = 1'b0;
    endtask
endmodule

/* File: test/tb.sv */
`timescale 1ns/10ps
module tb;
    import eirq_pkg::*;
    logic        clk_sys_in, rst_in, sfr_wr, sfr_rd, port_latch, port_dir, mie, nmi;
    logic        fetch_valid, trap_sel, trap_ack, func;
    logic [5:0]  sfr_addr;
    logic [7:0]  sfr_wdata;
    logic [15:0] fetch_addr;
    logic [2:0]  en, clr;
    wire  [7:0]  sfr_rdata_out;
    wire  [2:0]  pins, lat, req;
    wire         pad, pout, poe, prd, trap_reset_out, address_trap_irq_out, trap_abort_out;
    int          mismatches, n_tests, cycles;

    // the pad: port driver wins while enabled, otherwise the source's level
    assign pad = poe ? pout : pins[0];

    eirq_pin_src eirq_pin_src_i (.clk_sys_in(clk_sys_in), .pins_out(pins));

    eirq_ext_irq_ctrl eirq_ext_irq_ctrl_i (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr),
        .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd), .sfr_wdata_in(sfr_wdata),
        .sfr_rdata_out(sfr_rdata_out), .shared_port_bit_in(pad),
        .ext_irq_b_in(pins[1]), .ext_irq_c_in(pins[2]), .port_latch_in(port_latch),
        .port_dir_out_in(port_dir), .shared_port_bit_out(pout),
        .shared_port_bit_oe_out(poe), .shared_port_bit_rd_out(prd),
        .master_irq_enable_in(mie), .irq_a_enable_flag_in(en[0]),
        .irq_b_enable_flag_in(en[1]), .irq_c_enable_flag_in(en[2]),
        .irq_a_clear_in(clr[0]), .irq_b_clear_in(clr[1]), .irq_c_clear_in(clr[2]),
        .nmi_active_in(nmi), .irq_a_latch_out(lat[0]), .irq_b_latch_out(lat[1]),
        .irq_c_latch_out(lat[2]), .irq_a_req_out(req[0]), .irq_b_req_out(req[1]),
        .irq_c_req_out(req[2]), .fetch_valid_in(fetch_valid), .fetch_addr_in(fetch_addr),
        .wdt_trap_reset_sel_in(trap_sel), .trap_ack_in(trap_ack),
        .trap_reset_out(trap_reset_out), .address_trap_irq_out(address_trap_irq_out),
        .trap_abort_out(trap_abort_out));

    // free-running clock, 8 ns period
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // hang guard: the whole sequence needs under two thousand cycles
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys_in);
        sfr_wr = 1'b0;
    endtask

    // write then read in the very next cycle, as back-to-back access allows
    task automatic wr_rd(input logic [5:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(negedge clk_sys_in);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys_in);
        sfr_wr = 1'b0;
        sfr_rd = 1'b1;
        @(negedge clk_sys_in);
        sfr_rd = 1'b0;
        chk(sfr_rdata_out, exp);
    endtask

    // read data is registered, so it is looked at one cycle after the strobe
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(negedge clk_sys_in);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys_in);
        sfr_rd = 1'b0;
        chk(sfr_rdata_out, exp);
    endtask

    // low pulse on one pin; optional look and clear while low, so a later
    // unselected edge shows up; then latch, request, clear
    task automatic pulse(input int which, input int width, input int mid,
                         input logic mid_exp, input logic exp);
        logic req_exp;
        fork
            eirq_pin_src_i.low_pulse(which, width);
            if (mid > 0) begin
                repeat (mid) @(negedge clk_sys_in);
                chk(8'(lat[which]), 8'(mid_exp));
                clr[which] = 1'b1;
                @(negedge clk_sys_in);
                clr[which] = 1'b0;
            end
        join
        // 140 cycles covers the longest filter count plus sync and latch stages
        repeat (140) @(negedge clk_sys_in);
        req_exp = exp & mie & en[which] & ((which != 0) | func);
        chk(8'(lat[which]), 8'(exp));
        chk(8'(req[which]), 8'(req_exp));
        clr[which] = 1'b1;
        @(negedge clk_sys_in);
        clr[which] = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        chk(8'(lat[which]), 8'h00);
    endtask

    // one fetch, then the trap outputs in the cycle after, then acknowledge
    task automatic trap(input logic [15:0] addr, input logic sel, input logic hit);
        @(negedge clk_sys_in);
        fetch_valid = 1'b1;
        fetch_addr = addr;
        trap_sel = sel;
        @(negedge clk_sys_in);
        fetch_valid = 1'b0;
        chk(8'(trap_reset_out), 8'(hit & sel));
        chk(8'(address_trap_irq_out), 8'(hit & ~sel));
        chk(8'(trap_abort_out), 8'(hit & ~sel));
        trap_ack = 1'b1;
        @(negedge clk_sys_in);
        trap_ack = 1'b0;
        chk({5'h00, trap_reset_out, address_trap_irq_out, trap_abort_out}, 8'h00);
    endtask

    // main sequence
    initial begin
        {rst_in, sfr_wr, sfr_rd, port_latch, port_dir, mie, nmi} = 7'h40;
        {fetch_valid, trap_sel, trap_ack, func, en, clr} = 10'h000;
        sfr_addr = 6'h00;
        sfr_wdata = 8'h00;
        fetch_addr = 16'h0000;
        mismatches = 0;
        n_tests = 0;
        cycles = 0;
        repeat (2) @(negedge clk_sys_in);
        rst_in = 1'b0;
        rd(EIRQ_CTRL_ADDR, 8'h00);
        chk({poe, lat, req, prd}, 8'h01);
        port_dir = 1'b1;
        port_latch = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        chk({6'h00, poe, pout}, 8'h03);
        wr(EIRQ_CTRL_ADDR, 8'hFF);
        wr_rd(EIRQ_CTRL_ADDR, 8'hFF, 8'hC2);
        wr(6'h36, 8'hAA);
        rd(6'h36, 8'h00);
        rd(EIRQ_CTRL_ADDR, 8'hC2);
        chk({7'h00, poe}, 8'h00);
        wr(EIRQ_CTRL_ADDR, 8'h40);
        func = 1'b1;
        mie = 1'b1;
        en = 3'h7;
        pulse(0, 1, 0, 1'b0, 1'b0);
        pulse(0, 7, 0, 1'b0, 1'b1);
        pulse(2, 1, 0, 1'b0, 1'b0);
        pulse(2, 7, 0, 1'b0, 1'b1);
        pulse(1, 62, 0, 1'b0, 1'b0);
        pulse(1, 193, 140, 1'b0, 1'b1);
        mie = 1'b0;
        wr(EIRQ_CTRL_ADDR, 8'hC2);
        // the new length must be in force 64 cycles after the write
        repeat (64) @(negedge clk_sys_in);
        mie = 1'b1;
        pulse(1, 14, 0, 1'b0, 1'b0);
        pulse(1, 49, 40, 1'b1, 1'b0);
        mie = 1'b0;
        port_dir = 1'b0;
        wr(EIRQ_CTRL_ADDR, 8'h80);
        func = 1'b0;
        pulse(0, 7, 0, 1'b0, 1'b0);
        pulse(2, 7, 0, 1'b0, 1'b1);
        nmi = 1'b1;
        trap(16'h0080, 1'b0, 1'b1);
        trap(16'h00FF, 1'b1, 1'b1);
        trap(16'h0100, 1'b0, 1'b0);
        close_out();
    end
endmodule
